// >>> rtl/serial_flags_map.svh
/*
 Register offsets, field positions and reset values of the serial-port
 status and flow-control block. Assumes inclusion by bare name.
*/
`ifndef SERIAL_FLAGS_MAP_SVH
`define SERIAL_FLAGS_MAP_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define OFS_LINE_FLAGS 12'h000
`define OFS_DATA_PORT 12'h004
`define OFS_IRQ_CTRL 12'h010
`define OFS_STIM 12'h014

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define B_PARITY 0
`define B_FRAMING 1
`define B_NOISE 2
`define B_OVERRUN 3
`define B_IDLE 4
`define B_RXFULL 5
`define B_TDONE 6
`define B_TXEMPTY 7
`define B_BREAK 8
`define B_PEERCHG 9

// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define C_PE_IE 0
`define C_TXE_IE 1
`define C_TC_IE 2
`define C_RX_HOLDING_FULL_IE 3
`define C_IDLE_IE 4
`define C_BRK_IE 5
`define C_PEER_IE 6
`define C_ERR_IE 7
`define C_TX_HS 8
`define C_RX_HS 9
`define C_MULTI 10
`define C_ONEBIT 11
`define CTRL_W 12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LINE_FLAGS 10'h0c0
`define RST_CTRL 12'h000

`endif

// >>> rtl/serial_flags_pkg.sv
/*
 Types of the serial-port status block. Assumes no other package.
*/
package serial_flags_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_LOAD = 3'b010,
		TX_SEND = 3'b100
	} tx_state_t;
	typedef logic [8:0] word_t;
endpackage

// >>> rtl/serial_port_status_flow.sv
/*
 Status flags, shared interrupt request and peer-ready flow control of a
 serial transceiver, with an APB register slave.
 Assumes a frame shifter outside that reports receive events as one-cycle
 pulses and takes frames through a start/done handshake.
*/
`timescale 1ns/1ns
`default_nettype none
`include "serial_flags_map.svh"

module serial_port_status_flow
	import serial_flags_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [11:0] i_paddr,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_peer_ready_in_n,
	output logic o_rx_request_out_n,
	output logic o_irq,
	output logic o_tx_start,
	output logic [8:0] o_tx_data,
	input wire logic i_tx_frame_done,
	input wire logic i_rx_word_valid,
	input wire logic [8:0] i_rx_word,
	input wire logic i_rx_noise,
	input wire logic i_rx_framing,
	input wire logic i_rx_parity,
	input wire logic i_rx_idle,
	input wire logic i_rx_break
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic rd;
	logic hit_flags;
	logic hit_data;
	logic hit_ctrl;
	logic [9:0] flags_reg;
	logic [9:0] seen_reg;
	logic seq_armed_reg;
	logic [`CTRL_W-1:0] ctrl_reg;
	word_t tx_hold_reg;
	word_t rx_hold_reg;
	tx_state_t tx_state_reg;
	logic peer_s1_reg;
	logic peer_s2_reg;
	logic peer_prev_reg;
	logic [9:0] set_v;
	logic [9:0] clr_v;
	logic seq_clear;
	logic data_wr;
	logic data_rd;
	logic idle_armed_reg;
	logic mb_err_reg;

	function automatic logic zero_clear(input logic [31:0] d, input int b);
		return !d[b];
	endfunction

	assign acc = i_psel && i_penable;
	assign wr = acc && i_pwrite;
	assign rd = acc && !i_pwrite;
	assign hit_flags = i_paddr == `OFS_LINE_FLAGS;
	assign hit_data = i_paddr == `OFS_DATA_PORT;
	assign hit_ctrl = i_paddr == `OFS_IRQ_CTRL;
	assign o_pready = 1'b1;
	assign o_pslverr = acc && !(hit_flags || hit_data || hit_ctrl);
	assign data_wr = wr && hit_data;
	assign data_rd = rd && hit_data;

	// Read data is combinational from registered state, zero-wait access
	always_comb begin
		o_prdata = 32'h0000_0000;
		if (hit_flags) begin
			o_prdata = {22'h00_0000, flags_reg};
		end else if (hit_data) begin
			o_prdata = {23'h00_0000, rx_hold_reg};
		end else if (hit_ctrl) begin
			o_prdata = {20'h0_0000, ctrl_reg};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_reg <= `RST_CTRL;
		end else if (wr && hit_ctrl) begin
			ctrl_reg <= i_pwdata[`CTRL_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Peer-ready synchroniser and change detect
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			peer_s1_reg <= 1'b1;
			peer_s2_reg <= 1'b1;
			peer_prev_reg <= 1'b1;
		end else begin
			peer_s1_reg <= i_peer_ready_in_n;
			peer_s2_reg <= peer_s1_reg;
			peer_prev_reg <= peer_s2_reg;
		end
	end

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_hold_reg <= 9'h000;
		end else if (data_wr) begin
			tx_hold_reg <= i_pwdata[8:0];
		end
	end

	// Peer is checked only between frames so a drop never cuts one short
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_state_reg <= TX_IDLE;
			o_tx_data <= 9'h000;
		end else begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					if (!flags_reg[`B_TXEMPTY] &&
						(!ctrl_reg[`C_TX_HS] || !peer_s2_reg)) begin
						tx_state_reg <= TX_LOAD;
						o_tx_data <= tx_hold_reg;
					end
				end
				TX_LOAD: tx_state_reg <= TX_SEND;
				TX_SEND: begin
					if (i_tx_frame_done) begin
						tx_state_reg <= TX_IDLE;
					end
				end
				// A corrupted one-hot code falls back to idle
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end
	assign o_tx_start = tx_state_reg == TX_LOAD;

	// ----------------------------------------------------------------
	// Receive holding register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_hold_reg <= 9'h000;
		end else if (i_rx_word_valid && !flags_reg[`B_RXFULL]) begin
			rx_hold_reg <= i_rx_word;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx_request_out_n <= 1'b0;
		end else begin
			o_rx_request_out_n <= ctrl_reg[`C_RX_HS] &&
				flags_reg[`B_RXFULL];
		end
	end

	// ----------------------------------------------------------------
	// Flag set and clear
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			idle_armed_reg <= 1'b1;
		end else if (set_v[`B_RXFULL]) begin
			idle_armed_reg <= 1'b1;
		end else if (set_v[`B_IDLE]) begin
			idle_armed_reg <= 1'b0;
		end
	end

	// Flags present at the status read form the clear mask
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			seq_armed_reg <= 1'b0;
			seen_reg <= 10'h000;
		end else if (rd && hit_flags) begin
			seq_armed_reg <= 1'b1;
			seen_reg <= flags_reg;
		end else if (acc && hit_data) begin
			seq_armed_reg <= 1'b0;
		end
	end
	assign seq_clear = seq_armed_reg && acc && hit_data;

	always_comb begin
		logic ovr;
		ovr = i_rx_word_valid && flags_reg[`B_RXFULL];
		set_v = 10'h000;
		set_v[`B_PEERCHG] = ctrl_reg[`C_TX_HS] &&
			(peer_s2_reg != peer_prev_reg);
		set_v[`B_BREAK] = i_rx_break;
		set_v[`B_TXEMPTY] = o_tx_start;
		set_v[`B_TDONE] = i_tx_frame_done && tx_state_reg == TX_SEND &&
			flags_reg[`B_TXEMPTY];
		set_v[`B_RXFULL] = i_rx_word_valid && !flags_reg[`B_RXFULL];
		set_v[`B_IDLE] = i_rx_idle && idle_armed_reg;
		set_v[`B_OVERRUN] = ovr;
		set_v[`B_NOISE] = i_rx_word_valid && i_rx_noise &&
			!ctrl_reg[`C_ONEBIT];
		set_v[`B_FRAMING] = i_rx_word_valid && i_rx_framing && !ovr;
		set_v[`B_PARITY] = i_rx_word_valid && i_rx_parity;
		clr_v = 10'h000;
		if (wr && hit_flags) begin
			clr_v[`B_PEERCHG] = zero_clear(i_pwdata, `B_PEERCHG);
			clr_v[`B_BREAK] = zero_clear(i_pwdata, `B_BREAK);
			clr_v[`B_TDONE] = zero_clear(i_pwdata, `B_TDONE);
			clr_v[`B_RXFULL] = zero_clear(i_pwdata, `B_RXFULL);
		end
		if (data_wr) begin
			clr_v[`B_TXEMPTY] = 1'b1;
			clr_v[`B_TDONE] = clr_v[`B_TDONE] || (seq_clear &&
				seen_reg[`B_TDONE]);
		end
		if (data_rd) begin
			clr_v[`B_RXFULL] = 1'b1;
		end
		if (seq_clear && !i_pwrite) begin
			clr_v[`B_IDLE] = seen_reg[`B_IDLE];
			clr_v[`B_OVERRUN] = seen_reg[`B_OVERRUN];
			clr_v[`B_NOISE] = seen_reg[`B_NOISE];
			clr_v[`B_FRAMING] = seen_reg[`B_FRAMING];
		end
		if (seq_clear) begin
			clr_v[`B_PARITY] = seen_reg[`B_PARITY];
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flags_reg <= `RST_LINE_FLAGS;
		end else begin
			flags_reg <= (flags_reg & ~clr_v) | set_v;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt merge
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mb_err_reg <= 1'b0;
		end else begin
			mb_err_reg <= ctrl_reg[`C_MULTI] && ctrl_reg[`C_ERR_IE] &&
				(flags_reg[`B_NOISE] || flags_reg[`B_OVERRUN] ||
				flags_reg[`B_FRAMING]);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= (flags_reg[`B_PARITY] && ctrl_reg[`C_PE_IE]) ||
				(flags_reg[`B_TXEMPTY] && ctrl_reg[`C_TXE_IE]) ||
				(flags_reg[`B_TDONE] && ctrl_reg[`C_TC_IE]) ||
				((flags_reg[`B_RXFULL] || flags_reg[`B_OVERRUN]) &&
				ctrl_reg[`C_RX_HOLDING_FULL_IE]) ||
				(flags_reg[`B_IDLE] && ctrl_reg[`C_IDLE_IE]) ||
				(flags_reg[`B_BREAK] && ctrl_reg[`C_BRK_IE]) ||
				(flags_reg[`B_PEERCHG] && ctrl_reg[`C_PEER_IE]) ||
				mb_err_reg;
		end
	end

endmodule
`default_nettype wire

// >>> sim/status_flow_checker.sv
/* Port-level checks of the serial status block.
 Assumes binding onto every serial_port_status_flow instance. */
`timescale 1ns/1ns
`default_nettype none
`include "serial_flags_map.svh"
module status_flow_checker (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [11:0] i_paddr,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic o_irq,
	input wire logic o_rx_request_out_n,
	input wire logic o_tx_start,
	input wire logic [8:0] o_tx_data,
	input wire logic i_tx_frame_done
);
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_b);
logic rd_acc;
assign rd_acc = i_psel && i_penable && !i_pwrite;
logic in_frame_reg;
// Open from the cycle after a start until the edge that sees frame end
always_ff @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		in_frame_reg <= 1'b0;
	end else if (o_tx_start) begin
		in_frame_reg <= 1'b1;
	end else if (i_tx_frame_done) begin
		in_frame_reg <= 1'b0;
	end
end
sequence reset_gone;
	$rose(i_rst_b);
endsequence
sequence frame_quiet;
	$stable(o_tx_data) && !o_tx_start;
endsequence
property frame_held;
	in_frame_reg |-> frame_quiet;
endproperty
chk_flags_top_zero: assert property (
	rd_acc && i_paddr == `OFS_LINE_FLAGS |-> o_prdata[31:10] == 22'h0)
	else $error("flags upper bits not zero");
chk_hole_error: assert property (
	i_psel && i_penable && i_paddr == 12'h008 |-> o_pslverr)
	else $error("unmapped access not refused");
chk_hole_zero: assert property (
	rd_acc && i_paddr == 12'h008 |-> o_prdata == 32'h0)
	else $error("unmapped read not zero");
chk_flags_no_err: assert property (
	i_psel && i_penable && i_paddr == `OFS_LINE_FLAGS |-> !o_pslverr)
	else $error("flags access refused");
chk_frame_whole: assert property (frame_held)
	else $error("frame data moved or restarted mid-frame");
chk_reset_irq: assert property (reset_gone |-> !o_irq)
	else $error("irq high after reset");
chk_reset_rts: assert property (reset_gone |-> !o_rx_request_out_n)
	else $error("request line high after reset");
chk_reset_start: assert property (reset_gone |-> !o_tx_start)
	else $error("frame started at reset release");
endmodule
bind serial_port_status_flow status_flow_checker chk (
	.i_clk(i_clk),
	.i_rst_b(i_rst_b),
	.i_paddr(i_paddr),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.o_prdata(o_prdata),
	.o_pslverr(o_pslverr),
	.o_irq(o_irq),
	.o_rx_request_out_n(o_rx_request_out_n),
	.o_tx_start(o_tx_start),
	.o_tx_data(o_tx_data),
	.i_tx_frame_done(i_tx_frame_done)
);
`default_nettype wire

// >>> sim/peer_xcvr.sv
/* Peer transceiver: drives the peer-ready line, reports frame end.
 Assumes the bench decides when the peer is busy. */
`timescale 1ns/1ns
`default_nettype none
module peer_xcvr #(parameter int FRAME_LEN = 6) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_tx_start,
	input wire logic i_busy,
	output logic o_peer_ready_n,
	output logic o_frame_done
);
// ----------------------------------------
// Frame timing
// ----------------------------------------
logic [3:0] left_reg;
always_ff @(posedge i_clk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		left_reg <= 4'h0;
		o_frame_done <= 1'b0;
	end else begin
		o_frame_done <= left_reg == 4'h1;
		if (i_tx_start)
			left_reg <= 4'(FRAME_LEN);
		else if (left_reg != 4'h0)
			left_reg <= left_reg - 4'h1;
	end
end
// Busy only gates the next frame; the one in flight still ends
assign o_peer_ready_n = i_busy;
endmodule
`default_nettype wire

// >>> sim/tb.sv
/* Register-level tests of the serial status block.
 Assumes peer_xcvr as far side and the checker bound to the design. */
`timescale 1ns/1ns
`default_nettype none
`include "serial_flags_map.svh"
module tb;
// ----------------------------------------
// Stimulus and checks
// ----------------------------------------
logic clk, rst_b, psel, penable, pwrite, pready, pslverr, prn, rts_n;
logic irq, tx_start, done, rxv, busy;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, q;
logic [8:0] tx_data, rxw, last;
logic [2:0] rxq;
logic [1:0] ev;
int err_total, n_compared, starts, n;
localparam logic [11:0] fl = `OFS_LINE_FLAGS;
localparam logic [11:0] dp = `OFS_DATA_PORT;
localparam logic [11:0] cr = `OFS_IRQ_CTRL;
serial_port_status_flow dut (.i_clk(clk), .i_rst_b(rst_b), .i_paddr(paddr),
	.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
	.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
	.i_peer_ready_in_n(prn), .o_rx_request_out_n(rts_n), .o_irq(irq),
	.o_tx_start(tx_start), .o_tx_data(tx_data), .i_tx_frame_done(done),
	.i_rx_word_valid(rxv), .i_rx_word(rxw), .i_rx_noise(rxq[2]),
	.i_rx_framing(rxq[1]), .i_rx_parity(rxq[0]), .i_rx_idle(ev[0]),
	.i_rx_break(ev[1]));
peer_xcvr peer (.i_clk(clk), .i_rst_b(rst_b), .i_tx_start(tx_start),
	.i_busy(busy), .o_peer_ready_n(prn), .o_frame_done(done));
task automatic print_verdict();
	$display("compared %0d mismatched %0d", n_compared, err_total);
	if (err_total == 0 && n_compared > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
task automatic ck(input logic [31:0] s, input logic [31:0] e);
	n_compared++;
	if (s !== e) begin
		err_total++;
		$display("[FAIL] %0t seen %h expected %h", $time, s, e);
	end
endtask
task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
	psel <= 1'b1;
	paddr <= a;
	pwrite <= w;
	pwdata <= d;
	@(posedge clk);
	penable <= 1'b1;
	// Ready and read data are taken at the edge itself, before it updates
	do begin
		@(posedge clk);
	end while (pready !== 1'b1);
	q = prdata;
	psel <= 1'b0;
	penable <= 1'b0;
	// One idle cycle so no signal is driven twice in a step
	@(posedge clk);
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
	bus(a, 1'b1, d);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e);
	bus(a, 1'b0, 32'h0);
	ck(q, e);
endtask
task automatic rx(input logic [8:0] w, input logic [2:0] e);
	rxv <= 1'b1;
	rxw <= w;
	rxq <= e;
	@(posedge clk);
	rxv <= 1'b0;
	rxw <= ~w;
	rxq <= ~e;
	@(posedge clk);
endtask
task automatic pulse(input logic [1:0] k);
	ev <= k;
	@(posedge clk);
	ev <= 2'b00;
	@(posedge clk);
endtask
task automatic ckirq(input logic e);
	repeat (3) @(posedge clk);
	@(negedge clk);
	ck(32'(irq), e);
endtask
always @(negedge clk) begin
	if (tx_start === 1'b1) begin
		starts++;
		last = tx_data;
	end
end
initial begin
	clk = 1'b0;
	forever #25 clk = ~clk;
end
initial begin
	repeat (20000) @(posedge clk);
	err_total++;
	print_verdict();
end
initial begin
	{rst_b, psel, penable, pwrite, rxv, busy} = 6'h0;
	{paddr, pwdata, rxw, rxq, ev} = 58'h0;
	repeat (4) @(posedge clk);
	rst_b <= 1'b1;
	rd(fl, 10'h0c0);
	rd(12'h008, 1'b0);
	wr(fl, 32'hffff_ffff);
	rd(fl, 10'h0c0);
	$display("test 1 done");
	rx(9'h155, 3'b101);
	rd(fl, 10'h0e5);
	rx(9'h0aa, 3'b010);
	rd(fl, 10'h0ed);
	rd(dp, 9'h155);
	rd(fl, 10'h0c0);
	rx(9'h011, 3'b001);
	rd(dp, 9'h011);
	rd(fl, 10'h0c1);
	rx(9'h022, 3'b100);
	rd(dp, 9'h022);
	rd(fl, 10'h0c4);
	rd(dp, 9'h022);
	$display("test 2 done");
	pulse(2'b01);
	rd(fl, 10'h0d0);
	rd(dp, 9'h022);
	pulse(2'b01);
	rd(fl, 10'h0c0);
	rx(9'h033, 3'b000);
	pulse(2'b01);
	rd(fl, 10'h0f0);
	rd(dp, 9'h033);
	pulse(2'b10);
	rd(fl, 10'h1c0);
	wr(fl, 32'h0);
	rd(fl, 10'h080);
	$display("test 3 done");
	wr(cr, 12'h020);
	pulse(2'b10);
	ckirq(1'b1);
	wr(cr, 12'h000);
	ckirq(1'b0);
	wr(fl, 32'h0);
	wr(cr, 12'h002);
	ckirq(1'b1);
	wr(cr, 12'h080);
	rx(9'h044, 3'b100);
	ckirq(1'b0);
	wr(cr, 12'h480);
	ckirq(1'b1);
	wr(cr, 12'ha00);
	rd(fl, 10'h0a4);
	rd(dp, 9'h044);
	rx(9'h055, 3'b100);
	rd(fl, 10'h0a0);
	@(negedge clk);
	ck(32'(rts_n), 1'b1);
	rd(dp, 9'h055);
	@(negedge clk);
	ck(32'(rts_n), 1'b0);
	$display("test 4 done");
	wr(cr, 12'h100);
	busy <= 1'b1;
	wr(dp, 9'h1a5);
	repeat (12) @(posedge clk);
	ck(32'(starts), 1'b0);
	rd(fl, 10'h200);
	busy <= 1'b0;
	for (n = 0; starts == 0 && n < 40; n++)
		@(posedge clk);
	busy <= 1'b1;
	repeat (12) @(posedge clk);
	ck(32'(starts), 1'b1);
	ck(32'(last), 9'h1a5);
	rd(fl, 10'h2c0);
	wr(dp, 9'h0aa);
	rd(fl, 10'h200);
	wr(fl, 32'h0);
	rd(fl, 10'h000);
	wr(cr, 12'h000);
	repeat (20) @(posedge clk);
	ck(32'(starts), 2'h2);
	$display("test 5 done");
	print_verdict();
end
endmodule
`default_nettype wire
